// [inc/dfm_pkg.sv]
// package with register map, field positions, reset values and decode constants
`default_nettype none
package dfm_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [11:0] DFM_IDX_MAXPH_LO = 12'h10b; // max phase low byte
    localparam logic [11:0] DFM_IDX_MAXPH_HI = 12'h10c; // max phase high byte
    localparam logic [11:0] DFM_IDX_MASK     = 12'h10d; // failure mask
    localparam logic [11:0] DFM_IDX_STATUS   = 12'h1f0; // decoded status, read only
    localparam logic [13:0] DFM_ADR_MAXPH_LO = {DFM_IDX_MAXPH_LO, 2'b00};
    localparam logic [13:0] DFM_ADR_MAXPH_HI = {DFM_IDX_MAXPH_HI, 2'b00};
    localparam logic [13:0] DFM_ADR_MASK     = {DFM_IDX_MASK, 2'b00};
    localparam logic [13:0] DFM_ADR_STATUS   = {DFM_IDX_STATUS, 2'b00};
    // reset values
    localparam logic [15:0] DFM_MAXPH_RST = 16'h0000;
    localparam logic [7:0]  DFM_MASK_RST  = 8'h87;
    // mask field positions
    localparam int DFM_SW_GST  = 7;
    localparam int DFM_SW_CFM  = 6;
    localparam int DFM_SW_SCM  = 5;
    localparam int DFM_SW_LOS  = 4;
    localparam int DFM_HO_GST  = 3;
    localparam int DFM_HO_CFM  = 2;
    localparam int DFM_HO_SCM  = 1;
    localparam int DFM_HO_LOS  = 0;
    // decode constants, step in units of 0.1 us
    localparam logic [15:0] DFM_MAXPH_SAT  = 16'h03e8; // 1000 -> 100 us
    localparam logic [15:0] DFM_STEP_ZERO  = 16'h0064; // 100 tenths = 10 us
    // number of selectable references
    localparam int DFM_NREF = 11;
endpackage
`default_nettype wire

// [design/dfm_fail_gate.sv]
// per-reference failure gating and selection of the active reference
`default_nettype none
module dfm_fail_gate
    import dfm_pkg::*;
(
    input  wire logic [DFM_NREF-1:0] gst_fail_i,   // guard soak timer failures
    input  wire logic [DFM_NREF-1:0] cfm_fail_i,   // coarse frequency failures
    input  wire logic [DFM_NREF-1:0] scm_fail_i,   // single cycle failures
    input  wire logic [DFM_NREF-1:0] los_fail_i,   // signal loss, active high
    input  wire logic [3:0]          ref_sel_i,    // selected reference index
    input  wire logic [7:0]          mask_i,       // failure mask register
    output logic                     switch_req_o, // switch request
    output logic                     hold_req_o    // holdover request
);
    logic [DFM_NREF-1:0] sel_vec; // one-hot of selected reference
    logic [3:0]          sel_fail; // gst,cfm,scm,los of selected reference

    // one-hot decode, failures of unselected references drop out
    genvar g;
    generate
        for (g = 0; g < DFM_NREF; g++) begin : g_sel
            assign sel_vec[g] = (ref_sel_i == 4'(g));
        end
    endgenerate

    // pick the selected reference's failures
    always_comb begin
        sel_fail[3] = |(gst_fail_i & sel_vec);
        sel_fail[2] = |(cfm_fail_i & sel_vec);
        sel_fail[1] = |(scm_fail_i & sel_vec);
        sel_fail[0] = |(los_fail_i & sel_vec);
    end

    // switch decision from the upper mask nibble
    always_comb begin
        switch_req_o = (sel_fail[3] & mask_i[DFM_SW_GST])
                     | (sel_fail[2] & mask_i[DFM_SW_CFM])
                     | (sel_fail[1] & mask_i[DFM_SW_SCM])
                     | (sel_fail[0] & mask_i[DFM_SW_LOS]);
    end

    // holdover decision from the lower mask nibble
    always_comb begin
        hold_req_o = (sel_fail[3] & mask_i[DFM_HO_GST])
                   | (sel_fail[2] & mask_i[DFM_HO_CFM])
                   | (sel_fail[1] & mask_i[DFM_HO_SCM])
                   | (sel_fail[0] & mask_i[DFM_HO_LOS]);
    end
endmodule
`default_nettype wire

// [design/dfm_cfg_top.sv]
// first pll channel max-phase and failure-mask registers with wishbone slave
`default_nettype none
module dfm_cfg_top
    import dfm_pkg::*;
(
    input  wire logic                clk_i,           // system clock, 125 MHz
    input  wire logic                rst_i,           // synchronous reset, active high
    // classic wishbone slave
    input  wire logic                cyc_i,           // bus cycle
    input  wire logic                stb_i,           // strobe
    input  wire logic                we_i,            // write enable
    input  wire logic [15:0]         adr_i,           // byte address
    input  wire logic [3:0]          sel_i,           // byte selects
    input  wire logic [31:0]         dat_i,           // write data
    output logic      [31:0]         dat_o,           // read data
    output logic                     ack_o,           // acknowledge
    // monitor failures per reference, from logic on this clock
    input  wire logic [DFM_NREF-1:0] gst_fail_i,      // guard soak timer failures
    input  wire logic [DFM_NREF-1:0] cfm_fail_i,      // coarse frequency failures
    input  wire logic [DFM_NREF-1:0] scm_fail_i,      // single cycle failures
    input  wire logic [DFM_NREF-1:0] los_fail_i,      // external signal loss
    input  wire logic [3:0]          ref_sel_i,       // selected reference
    // outputs to the channel
    output logic                     switch_req_o,    // reference switch request
    output logic                     hold_req_o,      // holdover request
    output logic      [15:0]         max_step_o,      // max phase step, 0.1 us units
    output logic      [15:0]         max_phase_o,     // raw max phase setting
    output logic      [7:0]          mask_o           // raw failure mask
);
    logic [15:0] maxph_r;    // max phase setting
    logic [7:0]  mask_r;     // failure mask
    logic [15:0] step_r;     // decoded step
    logic [15:0] step_nxt;   // decoded step next value
    logic        ack_r;      // ack register
    logic [31:0] rdat_r;     // read data register
    logic [31:0] rdat_nxt;   // read mux
    logic        req;        // new request this cycle
    logic        wr_lo;      // write to low byte
    logic        wr_hi;      // write to high byte
    logic        wr_mask;    // write to mask
    logic        sw_c;       // combinational switch request
    logic        ho_c;       // combinational holdover request
    logic        sw_r;       // registered switch request
    logic        ho_r;       // registered holdover request

    // request accepted once per cycle, ack drops the cycle after
    assign req     = cyc_i & stb_i & ~ack_r;
    assign wr_lo   = req & we_i & sel_i[0] & (adr_i[13:0] == DFM_ADR_MAXPH_LO);
    assign wr_hi   = req & we_i & sel_i[0] & (adr_i[13:0] == DFM_ADR_MAXPH_HI);
    assign wr_mask = req & we_i & sel_i[0] & (adr_i[13:0] == DFM_ADR_MASK);

    // ack one cycle after request, every address answered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end
    assign ack_o = ack_r;

    // max phase register, two byte addresses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            maxph_r <= DFM_MAXPH_RST;
        end else begin
            if (wr_lo) begin
                maxph_r[7:0] <= dat_i[7:0];
            end
            if (wr_hi) begin
                maxph_r[15:8] <= dat_i[7:0];
            end
        end
    end

    // failure mask register, written as is (software keeps bits 3:1 legal)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= DFM_MASK_RST;
        end else if (wr_mask) begin
            mask_r <= dat_i[7:0];
        end
    end

    // decode the max phase step in tenths of a microsecond
    always_comb begin
        if (maxph_r == 16'h0000) begin
            step_nxt = DFM_STEP_ZERO;
        end else if (maxph_r <= DFM_MAXPH_SAT) begin
            step_nxt = maxph_r;
        end else begin
            step_nxt = DFM_MAXPH_SAT;
        end
    end

    // decoded step register; larger steps are only a slope limit hint
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_r <= DFM_STEP_ZERO;
        end else begin
            step_r <= step_nxt;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdat_nxt = 32'h0000_0000;
        unique case (adr_i[13:0])
            DFM_ADR_MAXPH_LO: begin
                rdat_nxt = {24'h00_0000, maxph_r[7:0]};
            end
            DFM_ADR_MAXPH_HI: begin
                rdat_nxt = {24'h00_0000, maxph_r[15:8]};
            end
            DFM_ADR_MASK: begin
                rdat_nxt = {24'h00_0000, mask_r};
            end
            DFM_ADR_STATUS: begin
                rdat_nxt = {14'h0, ho_r, sw_r, step_r};
            end
            default: begin
                rdat_nxt = 32'h0000_0000;
            end
        endcase
    end

    // read data register captured with the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_r <= 32'h0000_0000;
        end else if (req) begin
            rdat_r <= rdat_nxt;
        end
    end
    assign dat_o = rdat_r;

    // failure gating
    dfm_fail_gate u_gate (
        .gst_fail_i   (gst_fail_i),
        .cfm_fail_i   (cfm_fail_i),
        .scm_fail_i   (scm_fail_i),
        .los_fail_i   (los_fail_i),
        .ref_sel_i    (ref_sel_i),
        .mask_i       (mask_r),
        .switch_req_o (sw_c),
        .hold_req_o   (ho_c)
    );

    // register the requests
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_r <= 1'b0;
            ho_r <= 1'b0;
        end else begin
            sw_r <= sw_c;
            ho_r <= ho_c;
        end
    end

    assign switch_req_o = sw_r;
    assign hold_req_o   = ho_r;
    assign max_step_o   = step_r;
    assign max_phase_o  = maxph_r;
    assign mask_o       = mask_r;

    // assertions
    // the bus checks lean on the one-cycle answer: a request taken at one edge
    // shows ack for exactly the next cycle and read data until the next request, and a write has already
    // landed in the register by the time ack is seen
    // the gating checks only look at references 0..10; a select of 11..15 picks
    // nothing, so both requests must stay low then
    // the forbidden holdover pattern is the writer's duty and is stored as is,
    // so the mask checks only demand that the written byte lands and holds
    // everything is one cycle late because the requests and the step are flops

    // a taken request is answered in the next cycle
    a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o)
        else $error("request not acknowledged");

    // no strobe, no answer
    a_no_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");

    // ack always follows a strobed cycle
    a_ack_needs_cyc: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> $past(cyc_i && stb_i))
        else $error("ack not preceded by a strobe");

    // high byte write lands
    a_hi_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_hi |=> (max_phase_o[15:8] == $past(dat_i[7:0])))
        else $error("high byte write lost");

    // low byte write leaves the high byte alone
    a_lo_keeps_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lo && !wr_hi) |=> (max_phase_o[15:8] == $past(max_phase_o[15:8])))
        else $error("low byte write disturbed high byte");

    // high byte write leaves the low byte alone
    a_hi_keeps_lo: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_hi && !wr_lo) |=> (max_phase_o[7:0] == $past(max_phase_o[7:0])))
        else $error("high byte write disturbed low byte");

    // setting holds without a write
    a_maxph_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!wr_lo && !wr_hi) |=> (max_phase_o == $past(max_phase_o)))
        else $error("max phase changed without a write");

    // a write without the low byte select leaves the max phase setting alone
    a_wr_no_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && we_i && !sel_i[0]) |=> (max_phase_o == $past(max_phase_o)))
        else $error("write without byte select landed");

    // low byte read returns the setting
    a_rd_lo: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i[13:0] == DFM_ADR_MAXPH_LO) |=> (dat_o[7:0] == $past(maxph_r[7:0])))
        else $error("low byte read wrong");

    // high byte read returns the setting
    a_rd_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i[13:0] == DFM_ADR_MAXPH_HI) |=> (dat_o[7:0] == $past(maxph_r[15:8])))
        else $error("high byte read wrong");

    // mask read returns the mask
    a_rd_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i[13:0] == DFM_ADR_MASK) |=> (dat_o == {24'h00_0000, $past(mask_r)}))
        else $error("mask read wrong");

    // read data stands until the next request
    a_rdat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> (dat_o == $past(dat_o)))
        else $error("read data changed without a request");

    // an unmapped read returns zero
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i[13:0] == 14'h0440) |=> (dat_o == 32'h0000_0000))
        else $error("unmapped read not zero");

    // defaults right after reset
    a_rst_defaults: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (max_phase_o == 16'h0000 && mask_o == 8'h87 && max_step_o == 16'h0064))
        else $error("reset defaults wrong");

    // decoded step never zero and never above the saturation point
    a_step_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
        (max_step_o != 16'h0000 && max_step_o <= 16'h03e8))
        else $error("decoded step out of range");

    // mask holds without a write
    a_mask_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_mask |=> (mask_o == $past(mask_o)))
        else $error("mask changed without a write");

    // guard soak failure gated into switching
    a_sw_gst_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i < 4'hb && gst_fail_i[ref_sel_i] && mask_r[7]) |=> switch_req_o)
        else $error("guard soak failure did not request switch");

    // coarse frequency failure gated into switching
    a_sw_cfm_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i < 4'hb && cfm_fail_i[ref_sel_i] && mask_r[6]) |=> switch_req_o)
        else $error("coarse frequency failure did not request switch");

    // single cycle failure gated into switching
    a_sw_scm_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i < 4'hb && scm_fail_i[ref_sel_i] && mask_r[5]) |=> switch_req_o)
        else $error("single cycle failure did not request switch");

    // coarse frequency failure gated into holdover
    a_ho_cfm_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i < 4'hb && cfm_fail_i[ref_sel_i] && mask_r[2]) |=> hold_req_o)
        else $error("coarse frequency failure did not force holdover");

    // single cycle failure gated into holdover
    a_ho_scm_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i < 4'hb && scm_fail_i[ref_sel_i] && mask_r[1]) |=> hold_req_o)
        else $error("single cycle failure did not force holdover");

    // external signal loss gated into holdover
    a_ho_los_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i < 4'hb && los_fail_i[ref_sel_i] && mask_r[0]) |=> hold_req_o)
        else $error("signal loss did not force holdover");

    // no reference selected, no switch
    a_sw_unsel_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i >= 4'hb) |=> !switch_req_o)
        else $error("switch with no reference selected");

    // no reference selected, no holdover
    a_ho_unsel_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i >= 4'hb) |=> !hold_req_o)
        else $error("holdover with no reference selected");

    // no failure anywhere, both requests low
    a_no_fail_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (gst_fail_i == '0 && cfm_fail_i == '0 && scm_fail_i == '0 && los_fail_i == '0) |=> !switch_req_o && !hold_req_o)
        else $error("request without any failure");

    // failures of other references are ignored
    a_sw_only_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_sel_i < 4'hb && !gst_fail_i[ref_sel_i] && !cfm_fail_i[ref_sel_i] && !scm_fail_i[ref_sel_i] && !los_fail_i[ref_sel_i]) |=> !switch_req_o && !hold_req_o)
        else $error("unselected reference failure acted on");

    // status read shows both requests and the step
    a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && adr_i[13:0] == DFM_ADR_STATUS) |=> (dat_o == {14'h0, $past(ho_r), $past(sw_r), $past(step_r)}))
        else $error("status read wrong");

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_step_zero_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        (maxph_r == 16'h0000) |=> (max_step_o == 16'h0064))
        else $error("zero setting not decoded to 10 us");
    a_step_mid_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        (maxph_r != 16'h0000 && maxph_r <= 16'h03e8) |=> (max_step_o == $past(maxph_r)))
        else $error("mid setting decode wrong");
    a_step_sat_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        (maxph_r > 16'h03e8) |=> (max_step_o == 16'h03e8))
        else $error("setting not saturated");
    a_lo_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo |=> (max_phase_o[7:0] == $past(dat_i[7:0])))
        else $error("low byte write lost");
    a_mask_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_mask |=> (mask_o == $past(dat_i[7:0])))
        else $error("mask write lost");
    a_sw_los_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (los_fail_i[ref_sel_i] && mask_r[4] && ref_sel_i < 4'hb) |=> switch_req_o)
        else $error("signal loss did not request switch");
    a_ho_gst_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (gst_fail_i[ref_sel_i] && mask_r[3] && ref_sel_i < 4'hb) |=> hold_req_o)
        else $error("guard soak failure did not force holdover");
    a_ho_none_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask_r[3:0] == 4'h0) |=> !hold_req_o)
        else $error("holdover with all holdover bits masked");
    a_sw_none_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (mask_r[7:4] == 4'h0) |=> !switch_req_o)
        else $error("switch with all switch bits masked");
endmodule
`default_nettype wire

// [tb/dfm_cfg_top_tb.sv]
// self-checking bench for the max-phase and failure-mask registers
`default_nettype none
module dfm_cfg_top_tb import dfm_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk_i, rst_i, cyc_i, stb_i, we_i, ack_o; // clock, reset, bus
    logic [15:0]         adr_i, max_step_o, max_phase_o;         // address, decode
    logic [3:0]          sel_i, ref_sel_i;                       // selects, reference
    logic [31:0]         dat_i, dat_o, rd, rnd;                  // bus data, scratch
    logic [DFM_NREF-1:0] gst_fail_i, cfm_fail_i, scm_fail_i, los_fail_i; // failures
    logic                switch_req_o, hold_req_o;              // requests
    logic [7:0]          mask_o, mk, m;                          // mask, model mask
    logic [15:0]         mp;                                     // model max phase
    integer              seed = 32'h144a;                        // random seed
    int                  err_total, checked, cycles;             // counters
    dfm_cfg_top dfm_cfg_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .gst_fail_i(gst_fail_i), .cfm_fail_i(cfm_fail_i),
        .scm_fail_i(scm_fail_i), .los_fail_i(los_fail_i), .ref_sel_i(ref_sel_i),
        .switch_req_o(switch_req_o), .hold_req_o(hold_req_o), .max_step_o(max_step_o),
        .max_phase_o(max_phase_o), .mask_o(mask_o));
    // free-running 125 MHz clock
    always #4 clk_i = ~clk_i;
    // hang guard: a stuck handshake ends the run as a failure
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            err_total++;
            close_out();
        end
    end
    // verdict and end of run
    task automatic close_out();
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // compare one value with the model
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {2'b00, a};
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // model decode of the max phase setting, tenths of a microsecond
    function automatic logic [15:0] step_of(input int v);
        return (v == 0) ? 16'h0064 : ((v > 1000) ? 16'h03e8 : 16'(v));
    endfunction
    // write one max phase byte, then check raw value and decode
    task automatic wr_ph(input bit hi, input logic [7:0] v);
        rnd = $random(seed);
        wb(1'b1, hi ? DFM_ADR_MAXPH_HI : DFM_ADR_MAXPH_LO, {rnd[31:8], v}, 4'hf);
        if (hi) mp[15:8] = v;
        else mp[7:0] = v;
        @(negedge clk_i);
        check(32'(max_phase_o), 32'(mp));
        check(32'(max_step_o), 32'(step_of(int'(mp))));
    endtask
    // check requests against the model, directly and through status
    task automatic chk_req();
        logic sw, ho;
        @(posedge clk_i);
        sw = 1'b0;
        ho = 1'b0;
        if (ref_sel_i < DFM_NREF) begin
            sw = |({gst_fail_i[ref_sel_i], cfm_fail_i[ref_sel_i],
                    scm_fail_i[ref_sel_i], los_fail_i[ref_sel_i]} & mk[7:4]);
            ho = |({gst_fail_i[ref_sel_i], cfm_fail_i[ref_sel_i],
                    scm_fail_i[ref_sel_i], los_fail_i[ref_sel_i]} & mk[3:0]);
        end
        @(negedge clk_i);
        check({switch_req_o, hold_req_o}, {sw, ho});
        wb(1'b0, DFM_ADR_STATUS, 32'h0, 4'hf);
        check(rd, {14'h0, ho, sw, step_of(int'(mp))});
    endtask
    // main sequence
    initial begin
        int vals[8] = '{1, 2, 999, 1000, 1001, 4660, 65535, 0};
        clk_i = 0; rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0;
        adr_i = 0; sel_i = 0; dat_i = 0; ref_sel_i = 0;
        gst_fail_i = 0; cfm_fail_i = 0; scm_fail_i = 0; los_fail_i = 0;
        mp = 16'h0000;
        mk = 8'h87;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check({max_phase_o, mask_o, max_step_o}, {16'h0000, 8'h87, 16'h0064});
        wb(1'b0, DFM_ADR_MAXPH_LO, 32'h0, 4'hf);
        check(rd, 32'h0);
        wb(1'b0, DFM_ADR_MASK, 32'h0, 4'hf);
        check(rd, 32'h87);
        // decode table, low and high bytes written independently
        foreach (vals[i]) begin
            wr_ph(1'b0, 8'(vals[i]));
            wr_ph(1'b1, 8'(vals[i] >> 8));
            wb(1'b0, DFM_ADR_MAXPH_HI, 32'h0, 4'hf);
            check(rd, 32'(mp[15:8]));
        end
        // unmapped access and a write without byte select are ignored
        wb(1'b1, 14'h0440, 32'hff, 4'hf);
        wb(1'b0, 14'h0440, 32'h0, 4'hf);
        check(rd, 32'h0);
        wb(1'b1, DFM_ADR_MASK, 32'h55, 4'he);
        @(negedge clk_i);
        check(32'(mask_o), 32'(mk));
        // one-hot masks (bit 3 alone also gets bit 1), all clear, then random masks
        for (int i = 0; i < 12; i++) begin
            rnd = $random(seed);
            m = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'h00 : rnd[7:0]);
            if (m[3:1] == 3'b100) m[1] = 1'b1;
            wb(1'b1, DFM_ADR_MASK, {rnd[31:8], m}, 4'h1);
            mk = m;
            wb(1'b0, DFM_ADR_MASK, 32'h0, 4'hf);
            check(rd, 32'(mk));
            for (int k = 0; k < 6; k++) begin
                @(posedge clk_i);
                rnd = $random(seed);
                gst_fail_i <= (k == 0) ? '1 : DFM_NREF'($random(seed));
                cfm_fail_i <= (k == 0) ? '1 : DFM_NREF'($random(seed));
                scm_fail_i <= (k == 0) ? '1 : DFM_NREF'($random(seed));
                los_fail_i <= (k == 0) ? '1 : DFM_NREF'($random(seed));
                ref_sel_i  <= (k == 0) ? 4'h0 : rnd[3:0];
                chk_req();
            end
        end
        close_out();
    end
endmodule
`default_nettype wire
